// ---- rtl/watchdog_timer.sv ----
// watchdog timer counting rising edges of the low power rc oscillator
// assumes core events are single-cycle pulses on clk; rc clock is asynchronous
//
// Summary of operation
// - count only low power rc oscillator edges
// - enable rc oscillator whenever watchdog enabled
// - prescaler divides by 32 or 128
// - 4-bit postscaler selects 1:1 to 1:32768
// - device reset or clock switch clears counters
// - entering or leaving power save clears counters
// - clear instruction clears all counts
// - keep counting during sleep and idle
// - timeout in sleep/idle wakes, no reset
// - hardware enable forces watchdog always on
// - else software enable bit controls watchdog
// - device reset clears software enable
// - timeout flag sticky until software clears
module watchdog_timer
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // rc oscillator
  input wire logic lowPowerRcOsc,
  output logic rcOscEnable,
  // configuration word
  input wire logic hwWatchdogEnable,
  input wire logic prescaleSelect,
  input wire logic [3:0] postscaleSelect,
  // software control
  input wire logic swEnableSet,
  input wire logic swEnableClear,
  input wire logic timeoutFlagClear,
  // core events
  input wire logic watchdogClearInstr,
  input wire logic powerSaveInstr,
  input wire logic powerSaveIdle,
  input wire logic clockSwitchDone,
  // status
  output logic swWatchdogEnable,
  output logic timeoutFlag,
  output logic wakeRequest,
  output logic deviceResetReq,
  output logic inSleep,
  output logic inIdle
);
  wdt_sync_if sif ();
  assign sif.rawLevel = lowPowerRcOsc;
  // rc level synchroniser
  wdt_sync u_sync (
    .clk(clk),
    .rst(rst),
    .sif(sif)
  );

  // rc edge detector state
  logic rcPrev_r, rcPrev_nxt;
  // prescaler and postscaler counts
  logic [PRE_W-1:0] pre_r, pre_nxt;
  logic [POST_W:0] post_r, post_nxt;
  // software enable
  logic swEn_r, swEn_nxt;
  // status flops
  logic flag_r, flag_nxt;
  logic wake_r, wake_nxt;
  logic rstReq_r, rstReq_nxt;
  logic rcEn_r, rcEn_nxt;
  // power save state and its registered decodes
  pwr_state_t pwr_r, pwr_nxt;
  logic sleep_r, sleep_nxt;
  logic idle_r, idle_nxt;
  // shared decodes
  logic enabled;
  logic rcRise;
  logic preWrap;
  logic expire;
  logic inSave;
  logic exitSave;
  logic clearAll;
  logic [PRE_W-1:0] preLast;
  logic [POST_W:0] postLast;

  // last prescaler count before wrap, for the selected divide
  function automatic logic [PRE_W-1:0] preTerminal(input logic sel);
    if (sel) begin
      preTerminal = 7'(PRE_LONG - 1); // divide by 128
    end else begin
      preTerminal = 7'(PRE_SHORT - 1); // divide by 32
    end
  endfunction

  // postscale ratio as a count of prescaler overflows
  function automatic logic [POST_W:0] postRatio(input logic [3:0] sel);
    postRatio = 16'h0001 << sel;
  endfunction

  // enable, edge and terminal count decode
  always_comb begin
    enabled = hwWatchdogEnable | swEn_r;
    rcRise = sif.syncLevel & ~rcPrev_r;
    preLast = preTerminal(prescaleSelect);
    postLast = postRatio(postscaleSelect) - 16'h0001;
    preWrap = rcRise && (pre_r == preLast);
    expire = enabled && preWrap && (post_r == postLast);
    inSave = pwr_r != RUN_S;
    exitSave = inSave && expire;
    // counter clear: switch done, power save entry or exit, clear instruction
    clearAll = clockSwitchDone | powerSaveInstr;
    clearAll = clearAll | exitSave | watchdogClearInstr;
  end

  // rc edge detector next value
  always_comb begin
    rcPrev_nxt = sif.syncLevel;
  end

  // rc edge detector register; idles low like the stopped oscillator
  always_ff @(posedge clk) begin
    if (rst) begin
      rcPrev_r <= 1'b0;
    end else begin
      rcPrev_r <= rcPrev_nxt;
    end
  end

  // counter next values; any clear wins over counting
  always_comb begin
    pre_nxt = pre_r;
    post_nxt = post_r;
    if (clearAll || !enabled) begin
      pre_nxt = PRE_RST;
      post_nxt = POST_RST;
    end else if (expire) begin
      pre_nxt = PRE_RST; // restart after each timeout
      post_nxt = POST_RST;
    end else if (rcRise) begin
      if (preWrap) begin
        pre_nxt = PRE_RST;
        post_nxt = post_r + 16'h0001;
      end else begin
        pre_nxt = pre_r + 7'h01;
      end
    end
  end

  // counter registers; device reset clears both
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_r <= PRE_RST;
      post_r <= POST_RST;
    end else begin
      pre_r <= pre_nxt;
      post_r <= post_nxt;
    end
  end

  // software enable next value; set wins over clear
  always_comb begin
    swEn_nxt = swEn_r;
    if (swEnableClear) begin
      swEn_nxt = 1'b0;
    end
    if (swEnableSet) begin
      swEn_nxt = 1'b1;
    end
  end

  // software enable register; device reset clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      swEn_r <= 1'b0;
    end else begin
      swEn_r <= swEn_nxt;
    end
  end

  // status next values
  always_comb begin
    // sticky flag, set wins over clear
    flag_nxt = flag_r;
    if (timeoutFlagClear) begin
      flag_nxt = 1'b0;
    end
    if (expire) begin
      flag_nxt = 1'b1;
    end
    wake_nxt = exitSave;
    rstReq_nxt = expire && !inSave;
    rcEn_nxt = enabled;
  end

  // status registers
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_r <= 1'b0;
      wake_r <= 1'b0;
      rstReq_r <= 1'b0;
      rcEn_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      wake_r <= wake_nxt;
      rstReq_r <= rstReq_nxt;
      rcEn_r <= rcEn_nxt;
    end
  end

  // power save state next value; only a watchdog wake leaves it
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      RUN_S: begin
        if (powerSaveInstr) begin
          pwr_nxt = powerSaveIdle ? IDLE_S : SLEEP_S;
        end
      end
      SLEEP_S, IDLE_S: begin
        if (exitSave) begin
          pwr_nxt = RUN_S;
        end
      end
      default: begin
        pwr_nxt = RUN_S;
      end
    endcase
    sleep_nxt = pwr_nxt == SLEEP_S;
    idle_nxt = pwr_nxt == IDLE_S;
  end

  // power save registers; decodes kept as flops for the outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_r <= RUN_S;
      sleep_r <= 1'b0;
      idle_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      sleep_r <= sleep_nxt;
      idle_r <= idle_nxt;
    end
  end

  // outputs straight from flops
  assign rcOscEnable = rcEn_r;
  assign swWatchdogEnable = swEn_r;
  assign timeoutFlag = flag_r;
  assign wakeRequest = wake_r;
  assign deviceResetReq = rstReq_r;
  assign inSleep = sleep_r;
  assign inIdle = idle_r;
endmodule // watchdog_timer

// ---- include/wdt_pkg.sv ----
// watchdog package: counter widths, reset values, state codes
// assumes a single synchronous clock domain at 20 MHz
package wdt_pkg;
  localparam int PRE_SHORT = 32;          // prescale divide, select low
  localparam int PRE_LONG = 128;          // prescale divide, select high
  localparam int PRE_W = 7;
  localparam int POST_W = 15;             // ratios up to 1:32,768
  localparam logic [PRE_W-1:0] PRE_RST = 7'h00;
  localparam logic [POST_W:0] POST_RST = 16'h0000;
  localparam int RC_NOMINAL_KHZ = 32;     // nominal rc clock
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    RUN_S = 2'b00,
    SLEEP_S = 2'b01,
    IDLE_S = 2'b10
  } pwr_state_t;
endpackage

// ---- include/wdt_sync_if.sv ----
// interface carrying raw and synchronised rc clock level
// assumes both ends share clk
interface wdt_sync_if;
  logic rawLevel;
  logic syncLevel;
  modport src (output rawLevel, input syncLevel);
  modport syn (input rawLevel, output syncLevel);
endinterface

// ---- rtl/wdt_sync.sv ----
// two flip-flop synchroniser for the rc oscillator level
// assumes the level comes from outside the clk domain
module wdt_sync (
  input wire logic clk,
  input wire logic rst,
  wdt_sync_if.syn sif
);
  logic meta_r, meta_nxt, stab_r, stab_nxt;
  // next values
  always_comb begin
    meta_nxt = sif.rawLevel;
    stab_nxt = meta_r;
  end
  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      stab_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      stab_r <= stab_nxt;
    end
  end
  assign sif.syncLevel = stab_r;
endmodule // wdt_sync

// ---- verification/watchdog_timer_chk.sv ----
// port relation checker for the watchdog timer
// assumes binding onto watchdog_timer, one clock domain
module watchdog_timer_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration and software control
  input wire logic hwWatchdogEnable,
  input wire logic swEnableSet,
  input wire logic swEnableClear,
  input wire logic timeoutFlagClear,
  // core events
  input wire logic powerSaveInstr,
  input wire logic powerSaveIdle,
  // design outputs
  input wire logic rcOscEnable,
  input wire logic swWatchdogEnable,
  input wire logic timeoutFlag,
  input wire logic wakeRequest,
  input wire logic deviceResetReq,
  input wire logic inSleep,
  input wire logic inIdle
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // reset and enable
  AST_RESET_CLEARS: assert property
    ($fell(rst) |-> !swWatchdogEnable && !timeoutFlag) else $error("reset left state");
  AST_HW_ON: assert property
    (hwWatchdogEnable [*2] |-> rcOscEnable) else $error("rc off while forced on");
  AST_ALL_OFF: assert property
    ((!hwWatchdogEnable && !swWatchdogEnable) [*2] |-> !rcOscEnable) else $error("rc on");
  AST_SW_SET: assert property
    (swEnableSet |=> swWatchdogEnable) else $error("sw enable not set");
  AST_SW_CLR: assert property
    (swEnableClear && !swEnableSet |=> !swWatchdogEnable) else $error("sw enable not clear");
  // flag, wake, reset request and power save state
  AST_STICKY: assert property
    (timeoutFlag && !timeoutFlagClear |=> timeoutFlag) else $error("flag dropped");
  AST_WAKE: assert property
    (wakeRequest |-> timeoutFlag && !inSleep && !inIdle && !deviceResetReq)
    else $error("bad wake");
  AST_RESET_REQ: assert property
    (deviceResetReq |-> timeoutFlag ##1 !deviceResetReq) else $error("bad reset pulse");
  AST_POWER_SAVE: assert property
    (powerSaveInstr |=> inIdle == $past(powerSaveIdle) && inSleep != $past(powerSaveIdle))
    else $error("bad power save state");
  // main scenarios
  cover property (wakeRequest && $past(inIdle));
  cover property (deviceResetReq);
  cover property (swEnableSet && !hwWatchdogEnable);
endmodule // watchdog_timer_chk

bind watchdog_timer watchdog_timer_chk i_chk (.*);

// ---- verification/rc_osc_model.sv ----
// rc oscillator stand-in, 400 ns period to shorten counts
// assumes enable comes from the watchdog
module rc_osc_model (
  // control
  input wire logic enable,
  // clock out
  output logic osc
);
  timeunit 1ns;
  timeprecision 1ns;
  // toggles only while enabled, rests low otherwise
  initial begin
    osc = 1'b0;
    forever #200 osc = enable ? ~osc : 1'b0;
  end
endmodule // rc_osc_model

// ---- verification/watchdog_timer_tb.sv ----
// self-checking bench: periods, clears, software enable, sleep and idle
// assumes rc model period of 8 clk cycles
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("FAIL %0t got %h exp %h", $time, a, e); end end
module watchdog_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, osc, rcEn, hw = 1, pre = 0, swSet = 0, swClr = 0, flagClr = 0;
  logic clrI = 0, psI = 0, psIdle = 0, csDone = 0, swEn, flag, wake, rstReq, inSl, inId;
  logic [3:0] post = 4'h0;
  int failures = 0, tests_run = 0, cyc = 0, n;
  // clock and hang limit
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      test_done();
    end
  end
  rc_osc_model i_osc (.enable(rcEn), .osc(osc));
  watchdog_timer i_dut (.clk(clk), .rst(rst), .lowPowerRcOsc(osc), .rcOscEnable(rcEn),
    .hwWatchdogEnable(hw), .prescaleSelect(pre), .postscaleSelect(post), .swEnableSet(swSet),
    .swEnableClear(swClr), .timeoutFlagClear(flagClr), .watchdogClearInstr(clrI),
    .powerSaveInstr(psI), .powerSaveIdle(psIdle), .clockSwitchDone(csDone),
    .swWatchdogEnable(swEn), .timeoutFlag(flag), .wakeRequest(wake), .deviceResetReq(rstReq),
    .inSleep(inSl), .inIdle(inId));
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic waitFlag();
    n = 0;
    #1; // step off the edge that may clear the flag
    while (flag !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
  endtask
  // period per prescale and postscale, cleared by instruction or clock switch
  task automatic t_period();
    for (int p = 0; p < 4; p++) begin
      @(posedge clk);
      {pre, post, flagClr} <= {p[1], 3'h0, p[0], 1'b1};
      if (p[1]) csDone <= 1'b1; else clrI <= 1'b1;
      @(posedge clk);
      {flagClr, csDone, clrI} <= 3'h0;
      waitFlag();
      `CHK(n >= (256 << p) - 10 && n <= (256 << p) + 6, 1'b1)
      `CHK({rstReq, wake}, 2'h2)
    end
    $display("test period done");
  endtask
  // software enable governs only while hardware enable is low
  task automatic t_sw();
    @(posedge clk);
    {hw, pre, post, swClr, flagClr} <= 8'h03;
    @(posedge clk);
    {swClr, flagClr} <= 2'h0;
    tick(600);
    `CHK({flag, rcEn}, 2'h0)
    @(posedge clk) swSet <= 1'b1;
    @(posedge clk) swSet <= 1'b0;
    waitFlag();
    `CHK(flag, 1'b1)
    @(posedge clk) swClr <= 1'b1;
    @(posedge clk) swClr <= 1'b0;
    tick(1);
    `CHK({swEn, rcEn}, 2'h0)
    @(posedge clk) hw <= 1'b1;
    $display("test software enable done");
  endtask
  // timeout in sleep then idle wakes instead of resetting
  task automatic t_sleep();
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      {psI, psIdle, flagClr} <= {1'b1, m[0], 1'b1}; // timeout flag cleared on entry
      @(posedge clk);
      {psI, flagClr} <= 2'h0;
      tick(1);
      `CHK({inSl, inId}, {!m[0], m[0]})
      waitFlag();
      `CHK({wake, rstReq, inSl, inId}, 4'h8)
      tick(50);
      `CHK(flag, 1'b1)
    end
    $display("test sleep and idle done");
  endtask
  // reset in mid-run clears software enable and status
  task automatic t_reset();
    @(posedge clk) swSet <= 1'b1;
    @(posedge clk) swSet <= 1'b0;
    tick(1);
    `CHK({swEn, flag}, 2'h3)
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    `CHK({swEn, flag, rstReq, wake, inSl, inId}, 6'h00)
    $display("test mid-run reset done");
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    tick(10);
    rst <= 1'b0;
    t_period();
    t_sw();
    t_sleep();
    t_reset();
    test_done();
  end
endmodule // watchdog_timer_tb
